// >>> logic/sdpc_core.v
// serial command interface, double-buffered dac codes and power control
`timescale 1ns/1ps
`default_nettype none
`include "sdpc_defs.vh"

// Behaviour
// - frame is command byte then data byte
// - sample din on fall, drive dout on rise
// - first one after select low starts frame
// - start bit clears command and data shifters, starts counter
// - seven command bits, then eight data bits
// - command holds address, enables, shutdown, load
// - address selects one of four dacs or adc read
// - converter gain: direction bit, 7-bit code
// - modulator gain: adc channel bit, 7-bit code
// - bias: power class bits, 6-bit code
// - write fills input buffer only
// - load clear keeps active outputs
// - load set copies all buffers at frame end
// - read with load also copies buffers
// - read shifts adc result msb first, last eight
// - shutdown bit zero drives output low, bias off
// - serial interface works in every mode
// - rx/tx pair selects power mode
// - reset enters total shutdown
// - reset clears all dac codes
// - 6-bit and 7-bit codes, double-buffered
// - disabled varactor dac pulled to ground
// - sense inputs pulled down unless selected active
// - sense bias on only during transmit measurement

module sdpc_core (
    input wire clk,
    input wire resetn,
    input wire cs_n,
    input wire sclk,
    input wire din,
    input wire measure_window,
    input wire [7:0] adc_result,
    output reg dout,
    output reg dout_oe,
    output reg [5:0] varactor_dac,
    output reg [6:0] converter_gain_dac,
    output reg [6:0] modulator_gain_dac,
    output reg [5:0] bias_dac,
    output reg [1:0] power_class,
    output reg sense_forward,
    output reg direct_adc_channel,
    output reg bias_shutdown_out_n,
    output reg [1:0] power_mode,
    output reg varactor_dac_en,
    output reg converter_gain_dac_en,
    output reg modulator_gain_dac_en,
    output reg bias_dac_en,
    output reg varactor_pulldown,
    output reg [2:0] sense_pulldown,
    output reg sense_current_en,
    output reg sense_bias_out
);

    // ----------------------------------------------------------------
    // frame states, one-hot
    // ----------------------------------------------------------------
    localparam ST_IDLE = 5'h01;
    localparam ST_HUNT = 5'h02;
    localparam ST_CMD = 5'h04;
    localparam ST_DATA = 5'h08;
    localparam ST_DONE = 5'h10;

    // dac enables {varactor, converter, modulator, bias} per mode
    function [3:0] mode_enables;
        input [1:0] mode;
        input sd;
        begin
            case (mode)
                `SDPC_MODE_TRANSMIT: mode_enables = {3'h7, sd};
                `SDPC_MODE_RECEIVE: mode_enables = 4'ha;
                `SDPC_MODE_STANDBY: mode_enables = {3'h4, sd};
                default: mode_enables = 4'h0;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisation
    // ----------------------------------------------------------------
    wire [3:0] pins_sync;
    wire cs_n_s = pins_sync[3];
    wire sclk_s = pins_sync[2];
    wire din_s = pins_sync[1];
    wire window_s = pins_sync[0];

    sdpc_sync #(
        .WIDTH(4)
    ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .async_in({cs_n, sclk, din, measure_window}),
        .sync_out(pins_sync)
    );

    reg sclk_prev;
    wire sclk_fall = sclk_prev & ~sclk_s;
    wire sclk_rise = ~sclk_prev & sclk_s;

    // ----------------------------------------------------------------
    // frame state and shifters
    // ----------------------------------------------------------------
    reg [4:0] state;
    reg [`SDPC_CNT_W-1:0] bit_cnt;
    reg [`SDPC_CMD_W-1:0] cmd_sr;
    reg [7:0] data_sr;
    reg [7:0] out_sr;
    reg out_armed;
    reg frame_end;

    // input buffers, first half of the double buffer
    reg [5:0] buf_varactor;
    reg [6:0] buf_converter;
    reg [6:0] buf_modulator;
    reg [5:0] buf_bias;
    reg [1:0] buf_class;
    reg buf_forward;
    reg buf_direct;

    wire [2:0] cmd_addr = cmd_sr[`SDPC_CMD_ADDR_HI:`SDPC_CMD_ADDR_LO];
    wire cmd_load = cmd_sr[`SDPC_CMD_LD];
    wire [1:0] cmd_mode = {cmd_sr[`SDPC_CMD_RX_EN], cmd_sr[`SDPC_CMD_TX_EN]};
    wire cmd_sd = cmd_sr[`SDPC_CMD_SD];
    wire [6:0] next_cmd = {cmd_sr[`SDPC_CMD_W-2:0], din_s};
    wire [7:0] next_data = {data_sr[6:0], din_s};
    wire [2:0] next_addr = next_cmd[`SDPC_CMD_ADDR_HI:`SDPC_CMD_ADDR_LO];
    // result taken at the first data clock, so a read may precede conversion
    wire out_first = (bit_cnt == `SDPC_CNT_CMD_LAST + `SDPC_CNT_START);
    wire [7:0] out_word = out_first ? adc_result : out_sr;

    // sclk edges count only inside a selected frame; the interface never
    // looks at the power mode, so it runs in total shutdown as well
    always @(posedge clk) begin
        if (!resetn) begin
            sclk_prev <= 1'b0;
            state <= ST_IDLE;
            bit_cnt <= {`SDPC_CNT_W{1'b0}};
            cmd_sr <= {`SDPC_CMD_W{1'b0}};
            data_sr <= `SDPC_RST_BYTE;
            out_sr <= `SDPC_RST_BYTE;
            out_armed <= 1'b0;
            frame_end <= 1'b0;
            dout <= 1'b0;
            dout_oe <= 1'b0;
        end else begin
            sclk_prev <= sclk_s;
            frame_end <= 1'b0;
            dout_oe <= ~cs_n_s;
            if (cs_n_s) begin
                // early rise drops the frame, nothing is committed
                state <= ST_IDLE;
                out_armed <= 1'b0;
                dout <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        state <= ST_HUNT;
                    end
                    ST_HUNT: begin
                        if (sclk_fall && din_s) begin
                            cmd_sr <= {`SDPC_CMD_W{1'b0}};
                            data_sr <= `SDPC_RST_BYTE;
                            bit_cnt <= `SDPC_CNT_START;
                            state <= ST_CMD;
                        end
                    end
                    ST_CMD: begin
                        if (sclk_fall) begin
                            cmd_sr <= next_cmd;
                            bit_cnt <= bit_cnt + `SDPC_CNT_START;
                            if (bit_cnt == `SDPC_CNT_CMD_LAST) begin
                                state <= ST_DATA;
                                out_armed <= (next_addr == `SDPC_ADDR_ADC_READ);
                            end
                        end
                    end
                    ST_DATA: begin
                        if (sclk_rise && out_armed) begin
                            dout <= out_word[7];
                            out_sr <= {out_word[6:0], 1'b0};
                        end
                        if (sclk_fall) begin
                            data_sr <= next_data;
                            bit_cnt <= bit_cnt + `SDPC_CNT_START;
                            if (bit_cnt == `SDPC_CNT_FRAME_LAST) begin
                                state <= ST_DONE;
                                frame_end <= 1'b1;
                                out_armed <= 1'b0;
                            end
                        end
                    end
                    ST_DONE: begin
                        // wait for select to rise before the next frame
                        if (sclk_rise) begin
                            dout <= 1'b0;
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // input buffer writes at frame end
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (!resetn) begin
            buf_varactor <= `SDPC_RST_CODE6;
            buf_converter <= `SDPC_RST_CODE7;
            buf_modulator <= `SDPC_RST_CODE7;
            buf_bias <= `SDPC_RST_CODE6;
            buf_class <= `SDPC_RST_CLASS;
            buf_forward <= 1'b0;
            buf_direct <= 1'b0;
        end else if (frame_end) begin
            case (cmd_addr)
                `SDPC_ADDR_VARACTOR: begin
                    buf_varactor <= data_sr[`SDPC_CODE6_HI:0];
                end
                `SDPC_ADDR_CONV_GAIN: begin
                    buf_forward <= data_sr[`SDPC_DATA_FLAG];
                    buf_converter <= data_sr[`SDPC_CODE7_HI:0];
                end
                `SDPC_ADDR_MOD_GAIN: begin
                    buf_direct <= data_sr[`SDPC_DATA_FLAG];
                    buf_modulator <= data_sr[`SDPC_CODE7_HI:0];
                end
                `SDPC_ADDR_BIAS: begin
                    buf_class <= data_sr[`SDPC_CLASS_HI:`SDPC_CLASS_LO];
                    buf_bias <= data_sr[`SDPC_CODE6_HI:0];
                end
                default: begin
                    // reserved codes and adc read leave the buffers alone
                    buf_varactor <= buf_varactor;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // active registers, copied together on load
    // ----------------------------------------------------------------
    // the copy takes the buffer values including this frame's write, so
    // a single write with load set updates that dac in one frame
    always @(posedge clk) begin
        if (!resetn) begin
            varactor_dac <= `SDPC_RST_CODE6;
            converter_gain_dac <= `SDPC_RST_CODE7;
            modulator_gain_dac <= `SDPC_RST_CODE7;
            bias_dac <= `SDPC_RST_CODE6;
            power_class <= `SDPC_RST_CLASS;
            sense_forward <= 1'b0;
            direct_adc_channel <= 1'b0;
            bias_shutdown_out_n <= 1'b0;
            power_mode <= `SDPC_MODE_SHUTDOWN;
        end else if (frame_end && cmd_load) begin
            varactor_dac <= (cmd_addr == `SDPC_ADDR_VARACTOR) ?
                data_sr[`SDPC_CODE6_HI:0] : buf_varactor;
            converter_gain_dac <= (cmd_addr == `SDPC_ADDR_CONV_GAIN) ?
                data_sr[`SDPC_CODE7_HI:0] : buf_converter;
            modulator_gain_dac <= (cmd_addr == `SDPC_ADDR_MOD_GAIN) ?
                data_sr[`SDPC_CODE7_HI:0] : buf_modulator;
            bias_dac <= (cmd_addr == `SDPC_ADDR_BIAS) ?
                data_sr[`SDPC_CODE6_HI:0] : buf_bias;
            power_class <= (cmd_addr == `SDPC_ADDR_BIAS) ?
                data_sr[`SDPC_CLASS_HI:`SDPC_CLASS_LO] : buf_class;
            sense_forward <= (cmd_addr == `SDPC_ADDR_CONV_GAIN) ?
                data_sr[`SDPC_DATA_FLAG] : buf_forward;
            direct_adc_channel <= (cmd_addr == `SDPC_ADDR_MOD_GAIN) ?
                data_sr[`SDPC_DATA_FLAG] : buf_direct;
            bias_shutdown_out_n <= cmd_sd;
            power_mode <= cmd_mode;
        end
    end

    // ----------------------------------------------------------------
    // enables and pull-downs from the active state
    // ----------------------------------------------------------------
    wire [3:0] next_en = mode_enables(power_mode, bias_shutdown_out_n);
    // sense amplifier runs only in transmit with the window open
    wire next_sense_on = (power_mode == `SDPC_MODE_TRANSMIT) & window_s;
    // selected input: reverse, or forward a for class 1, else forward b
    wire [2:0] next_sel = !sense_forward ? 3'h1 :
        ((power_class == `SDPC_CLASS_1) ? 3'h2 : 3'h4);

    always @(posedge clk) begin
        if (!resetn) begin
            varactor_dac_en <= 1'b0;
            converter_gain_dac_en <= 1'b0;
            modulator_gain_dac_en <= 1'b0;
            bias_dac_en <= 1'b0;
            varactor_pulldown <= 1'b1;
            sense_current_en <= 1'b0;
            sense_bias_out <= 1'b0;
        end else begin
            varactor_dac_en <= next_en[3];
            converter_gain_dac_en <= next_en[2];
            modulator_gain_dac_en <= next_en[1];
            bias_dac_en <= next_en[0];
            varactor_pulldown <= ~next_en[3];
            sense_current_en <= next_sense_on;
            sense_bias_out <= next_sense_on;
        end
    end

    // one pull-down flop per sense input: bit 0 reverse, 1 forward a,
    // 2 forward b; unselected inputs stay grounded to limit coupling
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_pull
            always @(posedge clk) begin
                if (!resetn) begin
                    sense_pulldown[gi] <= 1'b1;
                end else begin
                    sense_pulldown[gi] <= ~(next_sense_on & next_sel[gi]);
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// >>> logic/sdpc_defs.vh
// constants of the serial dac and power control block
`ifndef SDPC_DEFS_VH
`define SDPC_DEFS_VH

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define SDPC_CNT_W 4
`define SDPC_CNT_START 4'h1
`define SDPC_CNT_CMD_LAST 4'h7
`define SDPC_CNT_FRAME_LAST 4'hf

// ----------------------------------------------------------------
// command byte fields, seven bits after the start bit
// ----------------------------------------------------------------
`define SDPC_CMD_W 7
`define SDPC_CMD_ADDR_HI 6
`define SDPC_CMD_ADDR_LO 4
`define SDPC_CMD_RX_EN 3
`define SDPC_CMD_TX_EN 2
`define SDPC_CMD_SD 1
`define SDPC_CMD_LD 0

// ----------------------------------------------------------------
// address codes
// ----------------------------------------------------------------
`define SDPC_ADDR_VARACTOR 3'h0
`define SDPC_ADDR_CONV_GAIN 3'h1
`define SDPC_ADDR_MOD_GAIN 3'h2
`define SDPC_ADDR_BIAS 3'h3
`define SDPC_ADDR_ADC_READ 3'h7

// ----------------------------------------------------------------
// data byte fields
// ----------------------------------------------------------------
`define SDPC_DATA_FLAG 7
`define SDPC_CLASS_HI 7
`define SDPC_CLASS_LO 6
`define SDPC_CODE6_HI 5
`define SDPC_CODE7_HI 6

// ----------------------------------------------------------------
// power modes {receive_enable_bit, transmit_enable_bit}
// ----------------------------------------------------------------
`define SDPC_MODE_SHUTDOWN 2'h0
`define SDPC_MODE_TRANSMIT 2'h1
`define SDPC_MODE_RECEIVE 2'h2
`define SDPC_MODE_STANDBY 2'h3
`define SDPC_CLASS_1 2'h0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SDPC_RST_CODE6 6'h00
`define SDPC_RST_CODE7 7'h00
`define SDPC_RST_BYTE 8'h00
`define SDPC_RST_CLASS 2'h0

`endif

// >>> logic/sdpc_sync.v
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none

module sdpc_sync #(
    parameter WIDTH = 4
) (
    input wire clk,
    input wire resetn,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] stage1;

    // ----------------------------------------------------------------
    // first stage feeds only the second
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (!resetn) begin
            stage1 <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

`default_nettype wire

// >>> tb/sdpc_core_properties.sv
// concurrent checks on the ports of the serial dac and power control core
`timescale 1ns/1ps
`default_nettype none
`include "sdpc_defs.vh"

module sdpc_core_properties (
    input wire logic clk,
    input wire logic resetn,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    input wire logic measure_window,
    input wire logic [7:0] adc_result,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic [5:0] varactor_dac,
    input wire logic [6:0] converter_gain_dac,
    input wire logic [6:0] modulator_gain_dac,
    input wire logic [5:0] bias_dac,
    input wire logic [1:0] power_class,
    input wire logic sense_forward,
    input wire logic direct_adc_channel,
    input wire logic bias_shutdown_out_n,
    input wire logic [1:0] power_mode,
    input wire logic varactor_dac_en,
    input wire logic converter_gain_dac_en,
    input wire logic modulator_gain_dac_en,
    input wire logic bias_dac_en,
    input wire logic varactor_pulldown,
    input wire logic [2:0] sense_pulldown,
    input wire logic sense_current_en,
    input wire logic sense_bias_out
);
    // ----------------------------------------------------------------
    // link and power control relations
    // ----------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // the pin passes two sync flops, so allow a few cycles
    property p_oe_on; $fell(cs_n) |-> ##[1:4] dout_oe; endproperty
    a_oe_on: assert property (p_oe_on) else $error("dout not enabled after select");
    property p_oe_off; $rose(cs_n) |-> ##[1:4] (!dout_oe && !dout); endproperty
    a_oe_off: assert property (p_oe_off) else $error("dout still driven");
    property p_quiet;
        cs_n [*4] |=> $stable(varactor_dac) && $stable(converter_gain_dac)
            && $stable(bias_dac) && $stable(power_mode) && $stable(bias_shutdown_out_n);
    endproperty
    a_quiet: assert property (p_quiet) else $error("outputs moved while deselected");
    // mode held two cycles, so the one-cycle enable lag is settled
    property p_var_pd;
        power_mode == `SDPC_MODE_SHUTDOWN && $past(power_mode) == `SDPC_MODE_SHUTDOWN
            |-> varactor_pulldown && !varactor_dac_en;
    endproperty
    a_var_pd: assert property (p_var_pd) else $error("varactor not pulled down");
    property p_tx_on;
        power_mode == `SDPC_MODE_TRANSMIT && $past(power_mode) == `SDPC_MODE_TRANSMIT
            |-> varactor_dac_en && converter_gain_dac_en && modulator_gain_dac_en;
    endproperty
    a_tx_on: assert property (p_tx_on) else $error("transmit enables wrong");
    property p_rx_off;
        power_mode == `SDPC_MODE_RECEIVE && $past(power_mode) == `SDPC_MODE_RECEIVE
            |-> !converter_gain_dac_en && !bias_dac_en && modulator_gain_dac_en;
    endproperty
    a_rx_off: assert property (p_rx_off) else $error("receive enables wrong");
    property p_stby;
        power_mode == `SDPC_MODE_STANDBY && $past(power_mode) == `SDPC_MODE_STANDBY
            |-> varactor_dac_en && !converter_gain_dac_en && !modulator_gain_dac_en;
    endproperty
    a_stby: assert property (p_stby) else $error("standby enables wrong");
    property p_sd; !bias_shutdown_out_n && !$past(bias_shutdown_out_n) |-> !bias_dac_en;
    endproperty
    a_sd: assert property (p_sd) else $error("bias dac on during shutdown");
    property p_sense_off;
        power_mode != `SDPC_MODE_TRANSMIT && $past(power_mode) != `SDPC_MODE_TRANSMIT
            |-> sense_pulldown == 3'h7 && !sense_current_en && !sense_bias_out;
    endproperty
    a_sense_off: assert property (p_sense_off) else $error("sense on outside transmit");
endmodule

bind sdpc_core sdpc_core_properties i_props (.clk, .resetn, .cs_n, .sclk, .din,
    .measure_window, .adc_result, .dout, .dout_oe, .varactor_dac, .converter_gain_dac,
    .modulator_gain_dac, .bias_dac, .power_class, .sense_forward, .direct_adc_channel,
    .bias_shutdown_out_n, .power_mode, .varactor_dac_en, .converter_gain_dac_en,
    .modulator_gain_dac_en, .bias_dac_en, .varactor_pulldown, .sense_pulldown,
    .sense_current_en, .sense_bias_out);
`default_nettype wire

// >>> tb/sdpc_core_tb.sv
// self-checking bench for the serial dac and power control core
`timescale 1ns/1ps
`default_nettype none
`include "sdpc_defs.vh"

module sdpc_core_tb;
    logic clk = 1'b0;
    logic resetn, measure_window, cs_n, sclk, din, dout, dout_oe;
    logic [7:0] adc_result;
    logic [5:0] varactor_dac, bias_dac;
    logic [6:0] converter_gain_dac, modulator_gain_dac;
    logic [1:0] power_class, power_mode;
    logic sense_forward, direct_adc_channel, bias_shutdown_out_n, varactor_pulldown;
    logic varactor_dac_en, converter_gain_dac_en, modulator_gain_dac_en, bias_dac_en;
    logic [2:0] sense_pulldown;
    logic sense_current_en, sense_bias_out;
    // expected buffers and active registers
    logic [5:0] vb, va;
    logic [7:0] cb, ca, mb, ma, bb, ba;
    logic [1:0] md;
    logic sd;
    int fails = 0;
    int n_compared = 0;
    int cycles = 0;

    sdpc_core i_dut (.clk, .resetn, .cs_n, .sclk, .din, .measure_window, .adc_result,
        .dout, .dout_oe, .varactor_dac, .converter_gain_dac, .modulator_gain_dac,
        .bias_dac, .power_class, .sense_forward, .direct_adc_channel,
        .bias_shutdown_out_n, .power_mode, .varactor_dac_en, .converter_gain_dac_en,
        .modulator_gain_dac_en, .bias_dac_en, .varactor_pulldown, .sense_pulldown,
        .sense_current_en, .sense_bias_out);
    sdpc_host_model i_host (.clk, .dout, .cs_n, .sclk, .din);

    // 20 MHz clock
    always #25 clk = ~clk;

    // hang guard, well above the roughly 7400 cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            fails++;
            tally_and_finish();
        end
    end

    // ----------------------------------------------------------------
    // expectations and comparisons
    // ----------------------------------------------------------------
    // dac enables {varactor, converter, modulator, bias}
    function automatic logic [3:0] exp_en(input logic [1:0] m, input logic s);
        case (m)
            `SDPC_MODE_TRANSMIT: exp_en = {3'b111, s};
            `SDPC_MODE_RECEIVE: exp_en = 4'b1010;
            `SDPC_MODE_STANDBY: exp_en = {3'b100, s};
            default: exp_en = 4'b0000;
        endcase
    endfunction

    // only the selected sense input is released, and only while measuring
    function automatic logic [2:0] exp_pd(input logic [1:0] m, input logic w);
        logic [2:0] sel;
        sel = !ca[7] ? 3'b001 : (ba[7:6] == `SDPC_CLASS_1 ? 3'b010 : 3'b100);
        exp_pd = (m == `SDPC_MODE_TRANSMIT && w) ? ~sel : 3'b111;
    endfunction

    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: output %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_read(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: read %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic check_all;
        logic [3:0] en;
        logic on;
        en = exp_en(md, sd);
        on = md == `SDPC_MODE_TRANSMIT && measure_window;
        chk_val(8'(varactor_dac), 8'(va));
        chk_val(8'({sense_forward, converter_gain_dac}), ca);
        chk_val(8'({direct_adc_channel, modulator_gain_dac}), ma);
        chk_val(8'({power_class, bias_dac}), ba);
        chk_val(8'(power_mode), 8'(md));
        chk_val(8'(bias_shutdown_out_n), 8'(sd));
        chk_val(8'({varactor_dac_en, converter_gain_dac_en, modulator_gain_dac_en,
            bias_dac_en}), 8'(en));
        chk_val(8'(varactor_pulldown), 8'(!en[3]));
        chk_val(8'(sense_pulldown), 8'(exp_pd(md, measure_window)));
        chk_val(8'({sense_current_en, sense_bias_out}), 8'({on, on}));
    endtask

    // one frame with fresh adc value and window level, then the model update
    task automatic run(input logic [6:0] cmd, input logic [7:0] data, input int nbits);
        logic [7:0] rd;
        logic [7:0] adc;
        adc = 8'($urandom);
        @(negedge clk);
        adc_result = adc;
        measure_window = 1'($urandom);
        // a new result lands after the command byte, as a finished conversion
        fork
            i_host.frame(cmd, data, nbits, rd);
            begin
                @(i_host.cmd_sent);
                adc = 8'($urandom);
                adc_result = adc;
            end
        join
        if (nbits == 16) begin
            case (cmd[6:4])
                `SDPC_ADDR_VARACTOR: vb = data[5:0];
                `SDPC_ADDR_CONV_GAIN: cb = data;
                `SDPC_ADDR_MOD_GAIN: mb = data;
                `SDPC_ADDR_BIAS: bb = data;
                default: ;
            endcase
            if (cmd[0]) begin
                {va, ca, ma, ba, md, sd} = {vb, cb, mb, bb, cmd[3:1]};
            end
            if (cmd[6:4] == `SDPC_ADDR_ADC_READ) chk_read(rd, adc);
        end
        check_all();
    endtask

    task automatic tally_and_finish;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'hb1da78e0));
        resetn = 1'b0;
        measure_window = 1'b0;
        adc_result = 8'h00;
        {vb, va, cb, ca, mb, ma, bb, ba, md, sd} = '0;
        repeat (5) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        check_all();
        run({`SDPC_ADDR_BIAS, 4'b0110}, 8'hff, 16);
        run({`SDPC_ADDR_CONV_GAIN, 4'b0111}, 8'h55, 10);
        i_host.gap = 30;
        run({`SDPC_ADDR_ADC_READ, 4'b0111}, 8'h00, 16);
        i_host.gap = 0;
        // every power mode with both shutdown bit values
        for (int k = 0; k < 8; k++) begin
            run({3'(k % 4), 3'(k), 1'b1}, 8'($urandom), 16);
        end
        for (int k = 0; k < 40; k++) begin
            run(7'($urandom), 8'($urandom), 16);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire

// >>> tb/sdpc_host_model.sv
// host side of the four-wire link: frames with start bit, command and data
`timescale 1ns/1ps
`default_nettype none

module sdpc_host_model (
    input wire logic clk,
    input wire logic dout,
    output logic cs_n,
    output logic sclk,
    output logic din
);
    // pause after the command byte; the link clock may stand at any time
    int gap = 0;
    event cmd_sent;

    // idle link: deselected, clock and data low
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
    end

    // one frame of 400 ns link clocks; nbits below 16 breaks it off early
    task automatic frame(input logic [6:0] cmd, input logic [7:0] data, input int nbits,
                         output logic [7:0] rd);
        logic [15:0] word;
        word = {1'b1, cmd, data};
        rd = 8'h00;
        @(negedge clk);
        cs_n = 1'b0;
        repeat (4) @(negedge clk);
        for (int i = 0; i < nbits; i++) begin
            din = word[15-i];
            sclk = 1'b1;
            repeat (4) @(negedge clk);
            sclk = 1'b0;
            // dout only moves after a rise, so the low half is safe
            repeat (2) @(negedge clk);
            if (i >= 8) rd[15-i] = dout;
            repeat (2) @(negedge clk);
            if (i == 7) begin
                -> cmd_sent;
                repeat (gap) @(negedge clk);
            end
        end
        din = 1'b0;
        repeat (6) @(negedge clk);
        cs_n = 1'b1;
        repeat (6) @(negedge clk);
    endtask
endmodule
`default_nettype wire
